// file: drx_top.v
// dual-bank configuration and status register file of the receiver
// assumes the serial front end hands over whole command and data bytes,
// one byte_valid pulse per data byte, all synchronous to core_clk_in
`timescale 1ns/1ps
`include "drx_regs.vh"
module drx_top (
	input  wire       core_clk_in,
	input  wire       rst_in,
	input  wire       cmd_valid_in,
	input  wire [7:0] cmd_byte_in,
	input  wire       byte_valid_in,
	input  wire [7:0] wr_data_in,
	input  wire       active_bank_a_in,
	input  wire       synth_lock_in,
	input  wire       low_volt_in,
	input  wire [3:0] lna_level_in,
	input  wire [3:0] if_level_in,
	output reg  [7:0] rd_data_out,
	output reg        byte_done_out,
	output wire       busy_out,
	output reg  [5:0] match_word_value_out,
	output reg  [2:0] match_word_length_out,
	output reg  [5:0] header_value_out,
	output reg  [2:0] header_length_out,
	output reg        strobe_osc_enable_out,
	output reg        low_volt_status_out
);

	localparam NUM = `DRX_NUM_REGS;

	// reset value of each implemented byte
	function [7:0] drx_rst_val;
		input integer idx;
		begin
			case (idx)
				0, 13:   drx_rst_val = `DRX_RST_CFG1;
				1, 14:   drx_rst_val = `DRX_RST_CFG2;
				2, 15:   drx_rst_val = `DRX_RST_CFG3;
				3, 16:   drx_rst_val = `DRX_RST_CMD;
				4, 17:   drx_rst_val = `DRX_RST_FHI;
				9, 22:   drx_rst_val = `DRX_RST_RXONOFF;
				10, 23:  drx_rst_val = `DRX_RST_ID;
				11, 24:  drx_rst_val = `DRX_RST_HDR;
				default: drx_rst_val = `DRX_RST_OTHER;
			endcase
		end
	endfunction

	// bits that a write may change; others are read-only
	function [7:0] drx_wmask;
		input integer idx;
		begin
			case (idx)
				13:      drx_wmask = 8'hF7;
				14:      drx_wmask = 8'hFE;
				2, 15:   drx_wmask = 8'hCF;
				3, 16:   drx_wmask = 8'hFE;
				12, 25:  drx_wmask = 8'h00;
				default: drx_wmask = 8'hFF;
			endcase
		end
	endfunction

	wire [4:0] acc_addr;
	wire       step;
	wire [7:0] byte_w [0:NUM-1];
	reg        wr_mode_r;
	reg        lvds_r;
	reg  [7:0] rd_mux;
	wire [2:0] id_len;
	wire [2:0] hd_len;
	wire [4:0] id_addr;
	wire [4:0] hd_addr;
	wire       mapped;
	wire       wr_hit;
	wire       cfg3_hit;

	// a byte is taken only inside a transfer
	assign step   = byte_valid_in && busy_out;
	assign mapped = (acc_addr <= `DRX_LAST_ADDR);
	// writes land in either bank whichever is active
	assign wr_hit = step && wr_mode_r && mapped;

	// direction of the transfer in progress
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in)
			wr_mode_r <= 1'b0;
		else if (cmd_valid_in && !busy_out)
			wr_mode_r <= cmd_byte_in[`DRX_CMD_WR_BIT];
	end

	// count code n selects n+1 registers
	drx_addr_ctr #(
		.AW (`DRX_ADDR_W)
	) u_ctr (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.load_in     (cmd_valid_in && !busy_out),
		.start_in    (cmd_byte_in[`DRX_CMD_A_MSB:0]),
		.count_in    ({1'b0, cmd_byte_in[`DRX_CMD_N_MSB:`DRX_CMD_N_LSB]} + 3'h1),
		.step_in     (step),
		.addr_out    (acc_addr),
		.busy_out    (busy_out)
	);

	// one byte flop per implemented location
	genvar i;
	generate
		for (i = 0; i < NUM; i = i + 1) begin : g_reg
			localparam [7:0] RV  = drx_rst_val(i);
			localparam [7:0] WM  = drx_wmask(i);
			localparam [4:0] IDX = i;
			reg [7:0] byte_r;
			assign byte_w[i] = byte_r;
			always @(posedge core_clk_in or posedge rst_in) begin
				if (rst_in)
					byte_r <= RV;
				else if (wr_hit && acc_addr == IDX)
					byte_r <= (byte_r & ~WM) | (wr_data_in & WM);
			end
		end
	endgenerate

	// any access to either copy of the third config byte
	assign cfg3_hit = step &&
		(acc_addr == `DRX_CFG3_A || acc_addr == `DRX_CFG3_B);

	// latched low-voltage flag; a new event beats the clear
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in)
			lvds_r <= 1'b0;
		else if (low_volt_in)
			lvds_r <= 1'b1;
		else if (cfg3_hit)
			lvds_r <= 1'b0;
	end

	// read view with shared, live and mirrored bits laid over storage
	always @* begin
		rd_mux = 8'h00;
		if (mapped)
			rd_mux = byte_w[acc_addr];
		case (acc_addr)
			`DRX_CFG2_B:
				rd_mux[`DRX_SOE_BIT] = byte_w[`DRX_CFG2_A][`DRX_SOE_BIT];
			`DRX_CFG3_A, `DRX_CFG3_B: begin
				rd_mux[`DRX_OLS_BIT]  = synth_lock_in;
				rd_mux[`DRX_LVDS_BIT] = lvds_r;
			end
			`DRX_CMD_A, `DRX_CMD_B:
				rd_mux[`DRX_BANKS_BIT] = active_bank_a_in;
			`DRX_SIGNAL_STRENGTH_A, `DRX_SIGNAL_STRENGTH_B:
				rd_mux = {lna_level_in, if_level_in};
			`DRX_CFG1_B:
				rd_mux[`DRX_RESET_BIT] = 1'b0;
			default: ;
		endcase
	end

	// read data and byte acknowledge, one cycle after the byte
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out   <= 8'h00;
			byte_done_out <= 1'b0;
		end else begin
			byte_done_out <= step;
			if (step && !wr_mode_r)
				rd_data_out <= rd_mux;
		end
	end

	// match fields of the active bank
	assign id_addr = active_bank_a_in ? `DRX_ID_A :
		`DRX_ID_A + `DRX_BANK_B_OFS;
	assign hd_addr = active_bank_a_in ? `DRX_HDR_A :
		`DRX_HDR_A + `DRX_BANK_B_OFS;

	drx_len_dec u_len (
		.id_code_in (byte_w[id_addr][`DRX_LEN_MSB:`DRX_LEN_LSB]),
		.hd_code_in (byte_w[hd_addr][`DRX_LEN_MSB:`DRX_LEN_LSB]),
		.id_len_out (id_len),
		.hd_len_out (hd_len)
	);

	// registered copies for the recognition datapath; the value bits keep
	// their lsb at bit 0 so short lengths use only the low symbols
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			match_word_value_out  <= 6'h00;
			match_word_length_out <= 3'h6;
			header_value_out      <= 6'h00;
			header_length_out     <= 3'h4;
			strobe_osc_enable_out <= 1'b0;
			low_volt_status_out   <= 1'b0;
		end else begin
			match_word_value_out  <= byte_w[id_addr][`DRX_VAL_MSB:0];
			match_word_length_out <= id_len;
			header_value_out      <= byte_w[hd_addr][`DRX_VAL_MSB:0];
			header_length_out     <= hd_len;
			strobe_osc_enable_out <= byte_w[`DRX_CFG2_A][`DRX_SOE_BIT];
			low_volt_status_out   <= lvds_r;
		end
	end

endmodule // drx_top

// file: drx_regs.vh
// constants of the dual-bank receiver configuration register file
// assumes a byte-wide serial front end delivers command and data bytes
// Function
// - identifier length code 00/01/10/11 selects 2/4/5/6 bits
// - identifier is Manchester symbols, its lsb always at register bit 0
// - header length code 00/01/10/11 selects 1/2/4/6 bits
// - header is Manchester coded, its lsb always at register bit 0
// - upper nibble of signal strength is the amplifier output level
// - lower nibble of signal strength is the level after the filter
// - signal strength reads live converter value from either bank
// - registers are bytes in a space of 32 locations
// - command gives start address and count; address steps per byte
// - writes over read-only bits are accepted and leave them unchanged
// - after the highest implemented register the address wraps to zero
// - any register of either bank is accessible at any time
// - read-and-clear bits clear on any read or write of their register
// - mirrored second-bank bits are read-only and show first-bank value
// - lock status is live synthesizer state, same in both banks
// - low-voltage bit latches detector, cleared by access from either bank
// - strobe enable writable in first bank only, second bank mirrors it
// - active-bank bit reads 1 for first bank, 0 for second, both banks
`ifndef DRX_REGS_VH
`define DRX_REGS_VH

// address space and map
`define DRX_ADDR_W        5
`define DRX_NUM_REGS      26
`define DRX_LAST_ADDR     5'h19
`define DRX_BANK_B_OFS    5'h0D
`define DRX_CFG1_A        5'h00
`define DRX_CFG2_A        5'h01
`define DRX_CFG3_A        5'h02
`define DRX_CMD_A         5'h03
`define DRX_FHI_A         5'h04
`define DRX_FLO_A         5'h05
`define DRX_RXONOFF_A     5'h09
`define DRX_ID_A          5'h0A
`define DRX_HDR_A         5'h0B
`define DRX_SIGNAL_STRENGTH_A        5'h0C
`define DRX_CFG1_B        5'h0D
`define DRX_CFG2_B        5'h0E
`define DRX_CFG3_B        5'h0F
`define DRX_CMD_B         5'h10
`define DRX_SIGNAL_STRENGTH_B        5'h19

// reset values
`define DRX_RST_CFG1      8'h91
`define DRX_RST_CFG2      8'h10
`define DRX_RST_CFG3      8'h30
`define DRX_RST_CMD       8'h09
`define DRX_RST_FHI       8'h48
`define DRX_RST_RXONOFF   8'h7F
`define DRX_RST_ID        8'hC0
`define DRX_RST_HDR       8'h80
`define DRX_RST_OTHER     8'h00

// field positions
`define DRX_SOE_BIT       0
`define DRX_LVDS_BIT      4
`define DRX_OLS_BIT       5
`define DRX_BANKS_BIT     0
`define DRX_RESET_BIT     3
`define DRX_LEN_MSB       7
`define DRX_LEN_LSB       6
`define DRX_VAL_MSB       5

// command byte layout
`define DRX_CMD_WR_BIT    7
`define DRX_CMD_N_MSB     6
`define DRX_CMD_N_LSB     5
`define DRX_CMD_A_MSB     4

`endif

// file: drx_len_dec.v
// length decoder for identifier and header match fields
// assumes two-bit codes come straight from register flops
`timescale 1ns/1ps
module drx_len_dec (
	input  wire [1:0] id_code_in,
	input  wire [1:0] hd_code_in,
	output reg  [2:0] id_len_out,
	output reg  [2:0] hd_len_out
);

	// identifier length in bits
	always @* begin
		case (id_code_in)
			2'h0:    id_len_out = 3'h2;
			2'h1:    id_len_out = 3'h4;
			2'h2:    id_len_out = 3'h5;
			default: id_len_out = 3'h6;
		endcase
	end

	// header length in bits
	always @* begin
		case (hd_code_in)
			2'h0:    hd_len_out = 3'h1;
			2'h1:    hd_len_out = 3'h2;
			2'h2:    hd_len_out = 3'h4;
			default: hd_len_out = 3'h6;
		endcase
	end

endmodule // drx_len_dec

// file: drx_addr_ctr.v
// auto-increment address counter with transfer count
// assumes load and step never coincide
`timescale 1ns/1ps
`include "drx_regs.vh"
module drx_addr_ctr #(
	parameter AW = 5
) (
	input  wire          core_clk_in,
	input  wire          rst_in,
	input  wire          load_in,
	input  wire [AW-1:0] start_in,
	input  wire [2:0]    count_in,
	input  wire          step_in,
	output reg  [AW-1:0] addr_out,
	output wire          busy_out
);

	reg [2:0] left_r;

	assign busy_out = (left_r != 3'h0);

	// load start, then step and count down per byte
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_out <= {AW{1'b0}};
			left_r   <= 3'h0;
		end else if (load_in) begin
			addr_out <= start_in;
			left_r   <= count_in;
		end else if (step_in && busy_out) begin
			left_r <= left_r - 3'h1;
			if (addr_out == `DRX_LAST_ADDR)
				addr_out <= {AW{1'b0}};
			else
				addr_out <= addr_out + {{(AW-1){1'b0}}, 1'b1};
		end
	end

endmodule // drx_addr_ctr

// file: drx_host.sv
// host model: command byte, then back-to-back data bytes
// assumes the bench calls xfer after reset release
`timescale 1ns/1ps
module drx_host (
	input  wire       clk_in,
	input  wire [7:0] rd_data_in,
	input  wire       done_in,
	output reg        cmd_valid_out,
	output reg  [7:0] cmd_byte_out,
	output reg        byte_valid_out,
	output reg  [7:0] wr_data_out
);
	reg [7:0] rd [0:3];
	initial begin
		cmd_valid_out = 1'b0;
		cmd_byte_out = 8'h00;
		byte_valid_out = 1'b0;
		wr_data_out = 8'h00;
	end
	// n+1 bytes follow the command; idle data is inverted so it never looks stale
	task xfer(input [7:0] cmd, input [31:0] wd);
		integer i, k;
		begin
			k = 0;
			cmd_valid_out <= 1'b1;
			cmd_byte_out <= cmd;
			for (i = 0; i < 8; i = i + 1) begin
				@(posedge clk_in);
				if (done_in === 1'b1 && k < 4) begin
					rd[k] = rd_data_in;
					k = k + 1;
				end
				// lowered once only, so a following call may raise it at this edge
				if (i == 0)
					cmd_valid_out <= 1'b0;
				byte_valid_out <= (i <= cmd[6:5]);
				wr_data_out <= (i <= cmd[6:5]) ? wd[8*i +: 8] : ~wr_data_out;
			end
		end
	endtask
endmodule // drx_host

// file: drx_top_asserts.sv
// port assertions for the register file
// assumes one clock and an async high reset
`timescale 1ns/1ps
module drx_top_asserts (
	input wire       core_clk_in,
	input wire       rst_in,
	input wire       cmd_valid_in,
	input wire       byte_valid_in,
	input wire       low_volt_in,
	input wire       byte_done_out,
	input wire       busy_out,
	input wire [2:0] match_word_length_out,
	input wire [2:0] header_length_out,
	input wire       strobe_osc_enable_out,
	input wire       low_volt_status_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	a_done_after_byte:
		assert property (byte_valid_in && busy_out |=> byte_done_out) else $error("no done");
	a_done_needs_byte:
		assert property (byte_done_out |-> $past(byte_valid_in && busy_out)) else $error("done");
	a_busy_on_cmd:
		assert property (cmd_valid_in && !busy_out |=> busy_out) else $error("no busy");
	a_busy_holds_on:
		assert property (busy_out && !byte_valid_in |=> busy_out) else $error("busy fell");
	a_low_volt_sets:
		assert property (low_volt_in |=> ##[0:1] low_volt_status_out) else $error("lv set");
	a_low_volt_clears:
		assert property ($fell(low_volt_status_out) |->
			$past(byte_valid_in) || $past(byte_valid_in, 2)) else $error("lv clear");
	a_id_len_legal:
		assert property (match_word_length_out inside {3'h2, 3'h4, 3'h5, 3'h6})
			else $error("id len");
	a_hdr_len_legal:
		assert property (header_length_out inside {3'h1, 3'h2, 3'h4, 3'h6})
			else $error("hdr len");
	a_soe_by_write:
		assert property ($changed(strobe_osc_enable_out) |->
			$past(byte_valid_in) || $past(byte_valid_in, 2)) else $error("soe");
	c_back_to_back: cover property (byte_valid_in && busy_out ##1 byte_valid_in && busy_out);
	c_lv_latched: cover property ($rose(low_volt_status_out));
	c_soe_set: cover property ($rose(strobe_osc_enable_out));
endmodule // drx_top_asserts
bind drx_top drx_top_asserts i_chk (.core_clk_in, .rst_in, .cmd_valid_in, .byte_valid_in,
	.low_volt_in, .byte_done_out, .busy_out, .match_word_length_out, .header_length_out,
	.strobe_osc_enable_out, .low_volt_status_out);

// file: tb.sv
// self-checking bench for the register file
// assumes drx_host drives the byte interface
`timescale 1ns/1ps
module tb;
	reg        clk, rst, bka, lock, lv;
	reg  [3:0] lna, ifl;
	reg  [7:0] r, s;
	integer    mismatches, check_count, i;
	wire       cv, bv, busy, done, strobe_osc_enable, lvs;
	wire [7:0] cb, wd, rd;
	wire [5:0] idv, hdv;
	wire [2:0] match_word_length, header_length;
	drx_top i_drx_top (.core_clk_in(clk), .rst_in(rst), .cmd_valid_in(cv), .cmd_byte_in(cb),
		.byte_valid_in(bv), .wr_data_in(wd), .active_bank_a_in(bka), .synth_lock_in(lock),
		.low_volt_in(lv), .lna_level_in(lna), .if_level_in(ifl), .rd_data_out(rd),
		.byte_done_out(done), .busy_out(busy), .match_word_value_out(idv),
		.match_word_length_out(match_word_length), .header_value_out(hdv), .header_length_out(header_length),
		.strobe_osc_enable_out(strobe_osc_enable), .low_volt_status_out(lvs));
	drx_host u_host (.clk_in(clk), .rd_data_in(rd), .done_in(done), .cmd_valid_out(cv),
		.cmd_byte_out(cb), .byte_valid_out(bv), .wr_data_out(wd));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input [7:0] g, input [7:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	function [7:0] idlen(input [1:0] c);
		idlen = (c == 2'h0) ? 8'h02 : (c == 2'h1) ? 8'h04 : (c == 2'h2) ? 8'h05 : 8'h06;
	endfunction
	function [7:0] hdlen(input [1:0] c);
		hdlen = (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h02 : (c == 2'h2) ? 8'h04 : 8'h06;
	endfunction
	task rd1(input [4:0] a);
		u_host.xfer({3'h0, a}, 32'h0);
	endtask
	task wr1(input [4:0] a, input [7:0] d);
		u_host.xfer({3'h4, a}, {24'h0, d});
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#50000;
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	initial begin
		rst = 1'b1;
		bka = 1'b1;
		lock = 1'b1;
		lv = 1'b0;
		lna = 4'h0;
		ifl = 4'h0;
		mismatches = 0;
		check_count = 0;
		r = $urandom(75);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		u_host.xfer(8'h60, 32'h0);
		chk(u_host.rd[0], 8'h91);
		chk(u_host.rd[1], 8'h10);
		chk(u_host.rd[2], 8'h20);
		chk(u_host.rd[3], 8'h09);
		chk({5'h0, match_word_length}, 8'h06);
		$display("reset test done");
		// every length code, random patterns, lsb at bit 0
		for (i = 0; i < 4; i = i + 1) begin
			r = $urandom;
			u_host.xfer(8'hAA, {16'h0, i[1:0], ~r[5:0], i[1:0], r[5:0]});
			chk({5'h0, match_word_length}, idlen(i[1:0]));
			chk({5'h0, header_length}, hdlen(i[1:0]));
			chk({2'h0, idv}, {2'h0, r[5:0]});
			chk({2'h0, hdv}, {2'h0, ~r[5:0]});
		end
		$display("length test done");
		// live levels, read from 18 wrapping past 19
		for (i = 0; i < 3; i = i + 1) begin
			r = $urandom;
			lna <= r[7:4];
			ifl <= r[3:0];
			@(posedge clk);
			u_host.xfer(8'h78, 32'h0);
			chk(u_host.rd[0], 8'h80);
			chk(u_host.rd[1], r);
			chk(u_host.rd[2], 8'h91);
			chk(u_host.rd[3], 8'h10);
			wr1(5'h0C, ~r);
			rd1(5'h0C);
			chk(u_host.rd[0], r);
		end
		wr1(5'h0D, 8'hFF);
		rd1(5'h0D);
		chk(u_host.rd[0], 8'hF7);
		$display("level test done");
		// strobe enable belongs to the first bank
		for (i = 0; i < 2; i = i + 1) begin
			s = {7'h08, ~i[0]};
			wr1(5'h01, s);
			wr1(5'h0E, s ^ 8'h01);
			rd1(5'h0E);
			chk(u_host.rd[0], s);
			chk({7'h0, strobe_osc_enable}, {7'h0, ~i[0]});
		end
		$display("strobe test done");
		// one-cycle detector pulse is latched, lock is live
		lock <= 1'b0;
		lv <= 1'b1;
		@(posedge clk);
		lv <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk({7'h0, lvs}, 8'h01);
		rd1(5'h0F);
		chk(u_host.rd[0], 8'h10);
		chk({7'h0, lvs}, 8'h00);
		rd1(5'h02);
		chk(u_host.rd[0], 8'h00);
		lock <= 1'b1;
		$display("status test done");
		// second bank active
		bka <= 1'b0;
		r = $urandom;
		wr1(5'h17, {2'h1, r[5:0]});
		u_host.xfer(8'h43, 32'h0);
		chk(u_host.rd[0], 8'h08);
		chk(u_host.rd[1], 8'h48);
		chk(u_host.rd[2], 8'h00);
		rd1(5'h10);
		chk(u_host.rd[0], 8'h08);
		chk({5'h0, match_word_length}, 8'h04);
		chk({2'h0, idv}, {2'h0, r[5:0]});
		rd1(5'h1A);
		chk(u_host.rd[0], 8'h00);
		$display("bank test done");
		tally_and_finish;
	end
endmodule // tb
